// *** src/i2cws_target.sv ***
// I2C register-write target port: address, pointer byte, data byte.
// Assumes an external bus controller, pull-ups on both lines, and a
// system clock of 125 MHz; the serial clock pin also clocks the
// link-side bit capture.
//
// Summary of operation
// - Strap low selects target address 0x68.
// - Strap high selects target address 0x69.
// - Only 7-bit addressing; ten-bit never matches.
// - Serial clock up to 1 MHz accepted.
// - SDA fall with SCL high marks START.
// - SDA rise with SCL high marks STOP.
// - Receiver holds SDA low through ninth clock.
// - STOP right after START is ignored.
// - Matching write address is acknowledged.
// - Pointer byte acknowledged, then data byte taken.
// - Acknowledged data byte is stored at STOP.
`timescale 1ns/1ps

`include "i2cws_cfg.svh"

module i2cws_target
	import i2cws_pkg::*;
#(
	parameter int IDLE_NORMAL_CYC = `I2CWS_IDLE_NORMAL_CYC,
	parameter int IDLE_LOWPWR_CYC = `I2CWS_IDLE_LOWPWR_CYC
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_serial_clock_pin,
	input wire logic i_serial_data_pin,
	output logic o_serial_data_pin,
	output logic o_serial_data_oe_n,
	input wire logic i_addr_select_pin,
	input wire logic i_low_power_mode,
	output logic o_bus_busy,
	output logic o_write_valid,
	output i2cws_write_t o_write,
	output logic o_idle_hold
);

	// Own address decode, used only at strap capture
	function automatic logic [6:0] own_address(input logic strap);
		own_address = strap ? `I2CWS_ADDR_STRAP_HIGH
			: `I2CWS_ADDR_STRAP_LOW;
	endfunction

	// Link-side capture: shift SDA in on every rising serial clock.
	// The word changes only at a rising edge, at least one full bit
	// period apart, so the system side reads it after it has seen the
	// same edge through the synchroniser and it is stable by then.
	logic [7:0] link_shift_reg;

	always_ff @(posedge i_serial_clock_pin)
	begin
		link_shift_reg <= {link_shift_reg[6:0], i_serial_data_pin};
	end

	// Pin levels into the system domain; idle bus reads high
	logic [2:0] pins_sync;
	logic scl_s;
	logic sda_s;
	logic strap_s;

	i2cws_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async({i_addr_select_pin, i_serial_data_pin,
			i_serial_clock_pin}),
		.i_reset_val(3'h3),
		.o_sync(pins_sync)
	);

	assign scl_s = pins_sync[0];
	assign sda_s = pins_sync[1];
	assign strap_s = pins_sync[2];

	// Previous synchronised levels for edge detection
	logic scl_d_reg;
	logic sda_d_reg;

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end
		else
		begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	// Bus events; at 1 MHz a phase is over 60 clocks, ample margin
	// oversampled edges
	wire scl_rise = scl_s & ~scl_d_reg;
	wire scl_fall = ~scl_s & scl_d_reg;
	wire scl_high = scl_s & scl_d_reg;
	wire start_det = scl_high & sda_d_reg & ~sda_s;
	wire stop_det = scl_high & ~sda_d_reg & sda_s;

	// Address strap caught once, on the third edge after release:
	// the synchroniser shows its reset value for the first two
	logic [1:0] strap_wait_reg;
	logic [6:0] own_addr_reg;
	wire strap_ready = (strap_wait_reg == 2'h2);

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			strap_wait_reg <= 2'h0;
			own_addr_reg <= `I2CWS_ADDR_STRAP_LOW;
		end
		else if (strap_wait_reg != 2'h3)
		begin
			strap_wait_reg <= strap_wait_reg + 2'h1;
			if (strap_ready)
			begin
				own_addr_reg <= own_address(strap_s);
			end
		end
	end

	// Clock activity since START; a STOP with none is not seen
	logic toggled_reg;
	logic toggled_next;
	logic busy_reg;
	logic busy_next;
	wire stop_ok = stop_det & toggled_reg;

	assign toggled_next = start_det ? 1'b0
		: (scl_fall ? 1'b1 : toggled_reg);
	assign busy_next = start_det ? 1'b1
		: (stop_ok ? 1'b0 : busy_reg);

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			toggled_reg <= 1'b0;
			busy_reg <= 1'b0;
		end
		else
		begin
			toggled_reg <= toggled_next;
			busy_reg <= busy_next;
		end
	end

	// Transaction state and bit position within the current byte
	i2cws_state_t state_reg;
	i2cws_state_t state_next;
	logic [3:0] bit_cnt_reg;
	logic [3:0] bit_cnt_next;
	logic ack_due_reg;
	logic ack_due_next;
	logic ack_drive_reg;
	logic ack_drive_next;
	logic [7:0] ptr_reg;
	logic [7:0] ptr_next;
	logic [7:0] data_reg;
	logic [7:0] data_next;
	logic pend_reg;
	logic pend_next;

	// Byte boundary: the eighth rising edge has just been seen
	wire byte_done = scl_rise & (bit_cnt_reg == `I2CWS_LAST_DATA_BIT);
	wire ack_rise = scl_rise & (bit_cnt_reg == `I2CWS_ACK_BIT);

	wire addr_hit = (link_shift_reg[`I2CWS_ADDR_MSB:`I2CWS_ADDR_LSB]
		== own_addr_reg)
		& (link_shift_reg[`I2CWS_DIR_BIT] == `I2CWS_DIR_WRITE);

	// Bit counter: nine clocks per byte, cleared by START
	assign bit_cnt_next = start_det ? 4'h0
		: (ack_rise ? 4'h0
		: (scl_rise ? bit_cnt_reg + 4'h1 : bit_cnt_reg));

	// Next state and captured fields
	always_comb
	begin
		state_next = state_reg;
		ptr_next = ptr_reg;
		data_next = data_reg;
		pend_next = pend_reg;
		ack_due_next = ack_due_reg;
		if (start_det)
		begin
			// Repeated START drops an unfinished write
			state_next = I2CWS_ADDR;
			pend_next = 1'b0;
			ack_due_next = 1'b0;
		end
		else if (stop_ok)
		begin
			state_next = I2CWS_IDLE;
			pend_next = 1'b0;
			ack_due_next = 1'b0;
		end
		else if (byte_done)
		begin
			case (state_reg)
				I2CWS_ADDR:
				begin
					state_next = addr_hit ? I2CWS_PTR : I2CWS_IGNORE;
					ack_due_next = addr_hit;
				end
				I2CWS_PTR:
				begin
					ptr_next = link_shift_reg;
					state_next = I2CWS_DATA;
					ack_due_next = 1'b1;
				end
				I2CWS_DATA:
				begin
					data_next = link_shift_reg;
					pend_next = 1'b1;
					state_next = I2CWS_EXTRA;
					ack_due_next = 1'b1;
				end
				I2CWS_EXTRA:
				begin
					// Single-byte writes only; further bytes refused
					ack_due_next = 1'b0;
				end
				I2CWS_IDLE:
				begin
					ack_due_next = 1'b0;
				end
				I2CWS_IGNORE:
				begin
					ack_due_next = 1'b0;
				end
				default:
				begin
					state_next = I2CWS_IDLE;
					ack_due_next = 1'b0;
				end
			endcase
		end
		else if (scl_fall & ack_due_reg)
		begin
			ack_due_next = 1'b0;
		end
	end

	// drive low from the fall after bit eight
	// to the fall after the ninth clock, so SDA is steady while high
	assign ack_drive_next = (start_det | stop_ok) ? 1'b0
		: ((scl_fall & ack_due_reg) ? 1'b1
		: ((scl_fall & (bit_cnt_reg == 4'h0)) ? 1'b0
		: ack_drive_reg));

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			state_reg <= I2CWS_IDLE;
			bit_cnt_reg <= 4'h0;
			ack_due_reg <= 1'b0;
			ack_drive_reg <= 1'b0;
			ptr_reg <= `I2CWS_PTR_RESET;
			data_reg <= `I2CWS_DATA_RESET;
			pend_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			ack_due_reg <= ack_due_next;
			ack_drive_reg <= ack_drive_next;
			ptr_reg <= ptr_next;
			data_reg <= data_next;
			pend_reg <= pend_next;
		end
	end

	// Store strobe: fires on the STOP that closes an acknowledged
	// data byte; a repeated START instead discards it
	logic wr_valid_reg;
	i2cws_write_t wr_reg;
	wire store_now = stop_ok & pend_reg;

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			wr_valid_reg <= 1'b0;
			wr_reg <= {`I2CWS_PTR_RESET, `I2CWS_DATA_RESET};
		end
		else
		begin
			wr_valid_reg <= store_now;
			if (store_now)
			begin
				wr_reg <= {ptr_reg, data_reg};
			end
		end
	end

	// Idle-time window after a write; the host must honour it, this
	// output only lets the core see how long the bus stays quiet
	logic [`I2CWS_IDLE_CNT_W-1:0] idle_cnt_reg;
	logic [`I2CWS_IDLE_CNT_W-1:0] idle_cnt_next;
	wire [`I2CWS_IDLE_CNT_W-1:0] idle_load = i_low_power_mode
		? `I2CWS_IDLE_CNT_W'(IDLE_LOWPWR_CYC)
		: `I2CWS_IDLE_CNT_W'(IDLE_NORMAL_CYC);

	assign idle_cnt_next = store_now ? idle_load
		: ((idle_cnt_reg != '0) ? idle_cnt_reg - 1'b1 : idle_cnt_reg);

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			idle_cnt_reg <= '0;
		end
		else
		begin
			idle_cnt_reg <= idle_cnt_next;
		end
	end

	// Open-drain data pin: only ever pulls low
	assign o_serial_data_pin = 1'b0;
	assign o_serial_data_oe_n = ~ack_drive_reg;
	assign o_bus_busy = busy_reg;
	assign o_write_valid = wr_valid_reg;
	assign o_write = wr_reg;
	assign o_idle_hold = (idle_cnt_reg != '0);

endmodule

// *** src/i2cws_cfg.svh ***
// Constants of the I2C register-write target port.
// Included by the target module and the bench; holds definitions only.
`ifndef I2CWS_CFG_SVH
`define I2CWS_CFG_SVH

// Target addresses chosen by the address-select strap
`define I2CWS_ADDR_STRAP_LOW 7'h68
`define I2CWS_ADDR_STRAP_HIGH 7'h69

// Direction bit value of a write
`define I2CWS_DIR_WRITE 1'h0

// Bit positions inside the address byte
`define I2CWS_ADDR_MSB 7
`define I2CWS_ADDR_LSB 1
`define I2CWS_DIR_BIT 0

// Last data bit index and position of the acknowledge clock
`define I2CWS_LAST_DATA_BIT 4'h7
`define I2CWS_ACK_BIT 4'h8

// Reset values
`define I2CWS_PTR_RESET 8'h00
`define I2CWS_DATA_RESET 8'h00

// System clock period and idle times in nanoseconds, serial clock limit in kHz
`define I2CWS_CLK_NS 8
`define I2CWS_SCL_MAX_KHZ 1000
`define I2CWS_IDLE_NORMAL_NS 1300
`define I2CWS_IDLE_LOWPWR_NS 400000

// Least times round up to whole clock cycles
`define I2CWS_IDLE_NORMAL_CYC \
	((`I2CWS_IDLE_NORMAL_NS + `I2CWS_CLK_NS - 1) / `I2CWS_CLK_NS)
`define I2CWS_IDLE_LOWPWR_CYC \
	((`I2CWS_IDLE_LOWPWR_NS + `I2CWS_CLK_NS - 1) / `I2CWS_CLK_NS)

// Width of the idle-time counter
`define I2CWS_IDLE_CNT_W 17

`endif

// *** src/i2cws_pkg.sv ***
// Types of the I2C register-write target port.
// Constants live in i2cws_cfg.svh; this package holds only types.
package i2cws_pkg;

	// One completed register write
	typedef struct packed {
		logic [7:0] reg_ptr;
		logic [7:0] reg_data;
	} i2cws_write_t;

	// Which byte of the transaction is being received
	typedef enum logic [2:0] {
		I2CWS_IDLE = 3'b000,
		I2CWS_ADDR = 3'b001,
		I2CWS_PTR = 3'b010,
		I2CWS_DATA = 3'b011,
		I2CWS_EXTRA = 3'b100,
		I2CWS_IGNORE = 3'b101
	} i2cws_state_t;

endpackage

// *** src/i2cws_sync.sv ***
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes each bit is a slow level relative to i_clk.
`timescale 1ns/1ps

module i2cws_sync #(
	parameter int WIDTH = 2
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [WIDTH-1:0] i_async,
	input wire logic [WIDTH-1:0] i_reset_val,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// First stage feeds only the second; reset value is a wired constant
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			meta_reg <= i_reset_val;
			sync_reg <= i_reset_val;
		end
		else
		begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end

	assign o_sync = sync_reg;

endmodule

// *** dv/i2cws_target_properties.sv ***
// Assertions on the write target's ports.
// Bound to i2cws_target; sees its ports only.
`timescale 1ns/1ps

module i2cws_target_properties
	import i2cws_pkg::*;
#(
	parameter int IDLE_NORMAL_CYC = 163,
	parameter int IDLE_LOWPWR_CYC = 50000
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_serial_clock_pin,
	input wire logic i_serial_data_pin,
	input wire logic o_serial_data_pin,
	input wire logic o_serial_data_oe_n,
	input wire logic i_addr_select_pin,
	input wire logic i_low_power_mode,
	input wire logic o_bus_busy,
	input wire logic o_write_valid,
	input wire i2cws_write_t o_write,
	input wire logic o_idle_hold
);
	int cnt_reg;
	logic lp_reg;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	// Idle window length, counted from the store
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
			cnt_reg <= 0;
		else if (o_write_valid)
			cnt_reg <= 1;
		else if (o_idle_hold)
			cnt_reg <= cnt_reg + 1;
	end

	// Mode latched at the store picks the length
	always_ff @(posedge i_clk)
	begin
		if (o_write_valid)
			lp_reg <= i_low_power_mode;
	end

	start_busy_a: assert property (
		$fell(i_serial_data_pin) && i_serial_clock_pin |-> ##[1:6] o_bus_busy)
		else $error("no busy after start");
	ack_scl_low_a: assert property (
		$fell(o_serial_data_oe_n) |-> !i_serial_clock_pin)
		else $error("ack began with clock high");
	ack_hold_a: assert property (
		i_serial_clock_pin |-> !$rose(o_serial_data_oe_n))
		else $error("ack ended with clock high");
	ack_len_a: assert property (
		$fell(o_serial_data_oe_n) |->
		!o_serial_data_oe_n[*8] ##[1:300] o_serial_data_oe_n)
		else $error("ack length wrong");
	valid_pulse_a: assert property (
		o_write_valid |-> !o_bus_busy ##1 !o_write_valid)
		else $error("store pulse wrong");
	store_stop_a: assert property (
		o_write_valid |-> $past(o_bus_busy) && $past(i_serial_clock_pin))
		else $error("store without stop");
	write_hold_a: assert property (
		$changed(o_write) |-> o_write_valid)
		else $error("write changed without store");
	idle_len_a: assert property (
		$fell(o_idle_hold) |->
		cnt_reg == (lp_reg ? IDLE_LOWPWR_CYC : IDLE_NORMAL_CYC))
		else $error("idle window length wrong");

	cover property (o_write_valid && i_low_power_mode);
	cover property ($fell(o_serial_data_oe_n));
	cover property ($fell(o_bus_busy));
endmodule

bind i2cws_target i2cws_target_properties #(
	.IDLE_NORMAL_CYC(IDLE_NORMAL_CYC),
	.IDLE_LOWPWR_CYC(IDLE_LOWPWR_CYC)
) i2cws_target_properties_inst (
	.i_clk, .i_reset_n, .i_serial_clock_pin, .i_serial_data_pin,
	.o_serial_data_pin, .o_serial_data_oe_n, .i_addr_select_pin,
	.i_low_power_mode, .o_bus_busy, .o_write_valid, .o_write, .o_idle_hold
);

// *** dv/i2cws_host_model.sv ***
// Bus controller model for the serial clock and data lines.
// Assumes a pull-up on the data line, resolved by the bench; the clock is driven directly.
`timescale 1ns/1ps

module i2cws_host_model (
	input wire logic i_link_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_oe_n
);
	// 504 ns half period, under 1 MHz
	localparam int HALF = 84;

	// Bus idles high; clock stands still between frames
	initial
	begin
		o_scl = 1'b1;
		o_sda_oe_n = 1'b1;
	end

	task automatic tick();
		repeat (HALF) @(posedge i_link_clk);
	endtask

	task automatic start();
		o_sda_oe_n = 1'b1;
		tick();
		o_scl = 1'b1;
		tick();
		o_sda_oe_n = 1'b0;
		tick();
		o_scl = 1'b0;
	endtask

	// MSB first, data released on ninth clock
	task automatic send(input logic [7:0] b, output logic ack);
		logic [8:0] f;
		f = {b, 1'b1};
		for (int i = 8; i >= 0; i--)
		begin
			o_sda_oe_n = f[i];
			tick();
			o_scl = 1'b1;
			tick();
			ack = !i_sda;
			o_scl = 1'b0;
		end
	endtask

	// data rises, clock high, then idle
	task automatic stop(input logic low_power);
		o_sda_oe_n = 1'b0;
		tick();
		o_scl = 1'b1;
		tick();
		o_sda_oe_n = 1'b1;
		#(low_power ? 400000 : 1300);
	endtask

	// bare start then stop, clock held high
	task automatic start_stop();
		o_sda_oe_n = 1'b0;
		tick();
		o_sda_oe_n = 1'b1;
		tick();
	endtask
endmodule

// *** dv/i2cws_target_test.sv ***
// Bench for the register-write target port.
// Host model drives the bus; pull-ups resolved here.
`timescale 1ns/1ps
`include "i2cws_cfg.svh"

module i2cws_target_test
	import i2cws_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic link_clk = 1'b0;
	logic strap = 1'b0;
	logic low_power = 1'b0;
	logic scl;
	logic host_oe_n;
	logic sda;
	logic dev_sda;
	logic dev_oe_n;
	logic busy;
	logic valid;
	i2cws_write_t wr;
	logic [15:0] exp_q[$];
	int err_total = 0;
	int compares = 0;

	always #4 i_clk = ~i_clk;

	// Odd offset keeps link edges off system edges
	initial
	begin
		#1.7;
		forever #3 link_clk = ~link_clk;
	end

	// Open-drain line, high unless pulled
	assign sda = host_oe_n & (dev_oe_n | dev_sda);

	i2cws_target #(
		.IDLE_NORMAL_CYC(20),
		.IDLE_LOWPWR_CYC(100)
	) i2cws_target_inst (
		.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_serial_clock_pin(scl), .i_serial_data_pin(sda),
		.o_serial_data_pin(dev_sda), .o_serial_data_oe_n(dev_oe_n),
		.i_addr_select_pin(strap), .i_low_power_mode(low_power),
		.o_bus_busy(busy), .o_write_valid(valid), .o_write(wr),
		.o_idle_hold()
	);

	i2cws_host_model host (
		.i_link_clk(link_clk), .i_sda(sda), .o_scl(scl),
		.o_sda_oe_n(host_oe_n)
	);

	task automatic check(input string what, input logic [15:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Strap is held through reset so it is settled at release
	task automatic do_reset(input logic s);
		@(posedge i_clk);
		i_reset_n <= 1'b0;
		strap <= s;
		repeat (5) @(posedge i_clk);
		i_reset_n <= 1'b1;
		repeat (3) @(posedge i_clk);
	endtask

	// One write frame; extra bytes follow the data byte
	task automatic frame(input logic [7:0] addr, input int extra);
		logic [7:0] ptr;
		logic [7:0] data;
		logic ack;
		logic hit;
		ptr = 8'($urandom);
		data = 8'($urandom);
		hit = addr[0] == `I2CWS_DIR_WRITE && addr[7:1] ==
			(strap ? `I2CWS_ADDR_STRAP_HIGH : `I2CWS_ADDR_STRAP_LOW);
		host.start();
		host.send(addr, ack);
		check("address ack", ack, hit);
		if (hit)
		begin
			host.send(ptr, ack);
			check("pointer ack", ack, 1'b1);
			host.send(data, ack);
			check("data ack", ack, 1'b1);
			repeat (extra)
			begin
				host.send(8'($urandom), ack);
				check("extra ack", ack, 1'b0);
			end
			exp_q.push_back({ptr, data});
		end
		host.stop(low_power);
	endtask

	// Each store is matched with the oldest note; outputs settled
	always @(negedge i_clk)
	begin
		if (valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("unexpected write", 16'h0001, 16'h0000);
			else
				check("stored write", wr, exp_q.pop_front());
		end
	end

	initial
	begin
		void'($urandom(32'hA8DE5A73));
		for (int s = 0; s < 2; s++)
		begin
			do_reset(s[0]);
			frame(8'hD0, 0);
			frame(8'hD2, 0);
		end
		frame(8'hD3, 0);
		frame(8'hF2, 0);
		frame(8'hD2, 1);
		@(posedge i_clk) low_power <= 1'b1;
		frame(8'hD2, 0);
		@(posedge i_clk) low_power <= 1'b0;
		host.start_stop();
		repeat (20) @(posedge i_clk);
		@(negedge i_clk);
		check("busy after bare stop", busy, 1'b1);
		frame(8'hD2, 0);
		check("pending writes", 16'(exp_q.size()), 16'h0000);
		wrap_up();
	end

	// Run needs about 0.62 ms; past 0.75 ms it has hung
	initial
	begin
		#750000;
		err_total++;
		wrap_up();
	end
endmodule
